// ### wdt_sleep_core.sv
// Overview of operation
// - Mode 11 runs watchdog always, ignores enable
// - Mode 10 runs awake, stops in sleep
// - Mode 01 follows software enable bit
// - Mode 00 keeps watchdog always off
// - Control bit 7 picks count clock
// - Prescale code sets ratio 32 times two^code
// - Reserved prescale codes act as 1:32
// - Prescale resets to code 01011
// - Clear, sleep, wake, control write clear count
// - Awake timeout requests device reset
// - Sleep timeout wakes, clears three flags
// - Sleep entry clears PD, sets TO, count
// - Sleep stops CPU clock; sys_clk keeps running
// - Pending interrupt turns sleep into no-op
// - Interrupt during sleep wakes immediately
// - Enabled interrupt wakes regardless of GLOBAL_INTERRUPT_ENABLE
// - Resets reset; watchdog/interrupt wakes resume
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module wdt_sleep_core
  import wdt_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic [1:0]        watchdog_mode_select,
  input  wire logic              lf_osc_pin,
  input  wire logic              mf_osc_pin,
  input  wire logic              clear_watchdog_instruction,
  input  wire logic              sleep_instruction,
  input  wire logic              enabled_irq_pending,
  input  wire logic              global_interrupt_enable,
  output logic                   watchdog_reset_request,
  output logic                   cpu_clock_enable,
  output logic                   sleeping,
  output logic                   wake_resume,
  output logic                   wake_to_isr
);

  // ----------------------------------------------------------------
  // Tick source
  // ----------------------------------------------------------------
  wdt_tick_if tick_bus ();

  wdt_tick_gen tick_gen
  (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .lf_osc_pin (lf_osc_pin),
    .mf_osc_pin (mf_osc_pin),
    .tick_bus   (tick_bus.src)
  );

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic              clk_sel_reg;
  logic              clk_sel_next;
  logic [4:0]        ps_reg;
  logic [4:0]        ps_next;
  logic              sen_reg;
  logic              sen_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              ctrl_write;
  logic              pd_reg;
  logic              to_reg;
  logic              watchdog_reset_flag_reg;

  assign ctrl_write = reg_write && (reg_addr == CTRL_ADDR);

  // Control write and registered read data; unmapped reads give zero
  always_comb
  begin
    clk_sel_next = clk_sel_reg;
    ps_next      = ps_reg;
    sen_next     = sen_reg;
    rdata_next   = '0;
    if (ctrl_write)
    begin
      clk_sel_next = reg_wdata[CLK_SEL_BIT];
      ps_next      = reg_wdata[PS_MSB:PS_LSB];
      sen_next     = reg_wdata[SEN_BIT];
    end
    if (reg_read && reg_addr == CTRL_ADDR)
    begin
      rdata_next[CLK_SEL_BIT]   = clk_sel_reg;
      rdata_next[PS_MSB:PS_LSB] = ps_reg;
      rdata_next[SEN_BIT]       = sen_reg;
    end
    else if (reg_read && reg_addr == STATUS_ADDR)
    begin
      rdata_next[STAT_PD_BIT]   = pd_reg;
      rdata_next[STAT_TO_BIT]   = to_reg;
      rdata_next[STAT_WATCHDOG_RESET_FLAG_BIT] = watchdog_reset_flag_reg;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      clk_sel_reg <= CLK_SEL_RESET;
      ps_reg      <= PS_RESET;
      sen_reg     <= SEN_RESET;
      rdata_reg   <= '0;
    end
    else
    begin
      clk_sel_reg <= clk_sel_next;
      ps_reg      <= ps_next;
      sen_reg     <= sen_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign reg_rdata        = rdata_reg;
  assign tick_bus.clk_sel = clk_sel_reg;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  power_state_t state_reg;
  power_state_t state_next;
  logic         active;

  // Configuration mode gates the counter against device state
  always_comb
  begin
    unique case (watchdog_mode_select)
      MODE_ALWAYS:     active = 1'b1;
      MODE_AWAKE_ONLY: active = (state_reg == PWR_AWAKE);
      MODE_SOFTWARE:   active = sen_reg;
      MODE_OFF:        active = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Counter, power state and flags
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [CNT_W-1:0] count_inc;
  logic             timeout;
  logic             sleep_enter;
  logic             sleep_nop;
  logic             irq_wake;
  logic             wdt_wake;
  logic             pd_next;
  logic             to_next;
  logic             watchdog_reset_flag_next;
  logic             rst_req_reg;
  logic             rst_req_next;
  logic             resume_reg;
  logic             resume_next;
  logic             isr_reg;
  logic             isr_next;

  assign count_inc   = count_reg + CNT_ONE;
  // Greater-or-equal covers a ratio lowered under a running count
  assign timeout     = active && tick_bus.tick && (count_inc >= ratio_of(ps_reg));
  assign sleep_enter = (state_reg == PWR_AWAKE) && sleep_instruction && !enabled_irq_pending;
  assign sleep_nop   = (state_reg == PWR_AWAKE) && sleep_instruction && enabled_irq_pending;
  // Any enabled interrupt wakes; GLOBAL_INTERRUPT_ENABLE only steers where execution goes
  assign irq_wake    = (state_reg == PWR_ASLEEP) && enabled_irq_pending;
  assign wdt_wake    = (state_reg == PWR_ASLEEP) && timeout && !irq_wake;

  // While awake, clears win over a same-cycle timeout: firmware kicked in time
  always_comb
  begin
    state_next   = state_reg;
    count_next   = count_reg;
    pd_next      = pd_reg;
    to_next      = to_reg;
    watchdog_reset_flag_next    = watchdog_reset_flag_reg;
    rst_req_next = 1'b0;
    resume_next  = 1'b0;
    isr_next     = 1'b0;
    if (active && tick_bus.tick)
    begin
      count_next = count_inc;
    end
    if (!active)
    begin
      count_next = CNT_ZERO;
    end
    if (state_reg == PWR_AWAKE)
    begin
      if (ctrl_write || clear_watchdog_instruction)
      begin
        count_next = CNT_ZERO;
      end
      else if (sleep_enter)
      begin
        state_next = PWR_ASLEEP;
        count_next = CNT_ZERO;
        pd_next    = 1'b0;
        to_next    = 1'b1;
      end
      else if (sleep_nop)
      begin
        count_next = count_reg;
      end
      else if (timeout)
      begin
        rst_req_next = 1'b1;
        watchdog_reset_flag_next    = 1'b0;
        count_next   = CNT_ZERO;
      end
    end
    else
    begin
      if (ctrl_write)
      begin
        count_next = CNT_ZERO;
      end
      if (irq_wake || wdt_wake)
      begin
        state_next  = PWR_AWAKE;
        count_next  = CNT_ZERO;
        resume_next = 1'b1;
        isr_next    = irq_wake && global_interrupt_enable;
      end
      if (wdt_wake)
      begin
        to_next   = 1'b0;
        pd_next   = 1'b0;
        watchdog_reset_flag_next = 1'b0;
      end
    end
  end

  // Any reset, including pin, brownout and power-on, lands here awake
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_reg   <= PWR_AWAKE;
      count_reg   <= CNT_ZERO;
      pd_reg      <= FLAG_RESET;
      to_reg      <= FLAG_RESET;
      watchdog_reset_flag_reg    <= FLAG_RESET;
      rst_req_reg <= 1'b0;
      resume_reg  <= 1'b0;
      isr_reg     <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      count_reg   <= count_next;
      pd_reg      <= pd_next;
      to_reg      <= to_next;
      watchdog_reset_flag_reg    <= watchdog_reset_flag_next;
      rst_req_reg <= rst_req_next;
      resume_reg  <= resume_next;
      isr_reg     <= isr_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the core
  // ----------------------------------------------------------------
  // Clock gate follows the state flop so it never glitches mid-cycle
  assign cpu_clock_enable       = (state_reg == PWR_AWAKE);
  assign sleeping               = (state_reg == PWR_ASLEEP);
  assign watchdog_reset_request = rst_req_reg;
  assign wake_resume            = resume_reg;
  assign wake_to_isr            = isr_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  mode_always_a: assert property (@(posedge sys_clk) disable iff (reset)
    (watchdog_mode_select == MODE_ALWAYS && state_reg == PWR_ASLEEP) |-> active)
    else $error("always-on mode idle in sleep");

  sleep_disable_a: assert property (@(posedge sys_clk) disable iff (reset)
    (watchdog_mode_select == MODE_AWAKE_ONLY && state_reg == PWR_ASLEEP)
      |-> (!active && !timeout))
    else $error("awake-only mode ran in sleep");

  mode_software_a: assert property (@(posedge sys_clk) disable iff (reset)
    (watchdog_mode_select == MODE_SOFTWARE) |-> (active == sen_reg))
    else $error("software mode ignores enable bit");

  mode_off_a: assert property (@(posedge sys_clk) disable iff (reset)
    (watchdog_mode_select == MODE_OFF) |=> (count_reg == CNT_ZERO && !watchdog_reset_request))
    else $error("off mode counted or reset");

  prescale_reset_a: assert property (@(posedge sys_clk)
    reset |=> (ps_reg == PS_RESET))
    else $error("prescale not at reset code");

  ratio_limit_a: assert property (@(posedge sys_clk) disable iff (reset)
    (active && count_reg >= ratio_of(ps_reg) && !$past(ctrl_write)) |-> !tick_bus.tick
      || timeout)
    else $error("count passed ratio without timeout");

  ctrl_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    ctrl_write |=> (count_reg == CNT_ZERO))
    else $error("control write left count");

  awake_timeout_a: assert property (@(posedge sys_clk) disable iff (reset)
    (timeout && state_reg == PWR_AWAKE && !ctrl_write && !clear_watchdog_instruction
      && !sleep_instruction) |=> (watchdog_reset_request && !watchdog_reset_flag_reg)
      ##1 !watchdog_reset_request)
    else $error("awake timeout gave no one-cycle reset request");

  sleep_timeout_a: assert property (@(posedge sys_clk) disable iff (reset)
    wdt_wake |=> (!to_reg && !pd_reg && !watchdog_reset_flag_reg && wake_resume && cpu_clock_enable
      && !watchdog_reset_request))
    else $error("sleep timeout did not wake cleanly");

  sleep_entry_a: assert property (@(posedge sys_clk) disable iff (reset)
    (sleep_enter && !ctrl_write && !clear_watchdog_instruction)
      |=> (sleeping && !pd_reg && to_reg && count_reg == CNT_ZERO && !cpu_clock_enable))
    else $error("sleep entry state wrong");

  sleep_nop_a: assert property (@(posedge sys_clk) disable iff (reset)
    (sleep_nop && !ctrl_write && !clear_watchdog_instruction && !timeout)
      |=> (!sleeping && $stable(pd_reg) && $stable(to_reg) && $stable(count_reg)))
    else $error("sleep no-op changed state");

  irq_wake_a: assert property (@(posedge sys_clk) disable iff (reset)
    irq_wake |=> (!sleeping && wake_resume && count_reg == CNT_ZERO
      && wake_to_isr == $past(global_interrupt_enable)))
    else $error("interrupt wake wrong");

endmodule
`default_nettype wire

// ### wdt_pkg.sv
package wdt_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 8;
  localparam logic [11:0] CTRL_ADDR       = 12'h80C;
  localparam logic [11:0] STATUS_ADDR     = 12'h80D;

  // ----------------------------------------------------------------
  // Control field layout and reset values
  // ----------------------------------------------------------------
  localparam int          SEN_BIT         = 0;
  localparam int          PS_LSB          = 1;
  localparam int          PS_MSB          = 5;
  localparam int          CLK_SEL_BIT     = 7;
  localparam logic [4:0]  PS_RESET        = 5'h0B;
  localparam logic [4:0]  PS_MAX          = 5'h12;
  localparam logic        SEN_RESET       = 1'h0;
  localparam logic        CLK_SEL_RESET   = 1'h0;

  // ----------------------------------------------------------------
  // Status field layout
  // ----------------------------------------------------------------
  localparam int          STAT_PD_BIT     = 0;
  localparam int          STAT_TO_BIT     = 1;
  localparam int          STAT_WATCHDOG_RESET_FLAG_BIT   = 2;
  localparam logic        FLAG_RESET      = 1'h1;

  // ----------------------------------------------------------------
  // Modes, counter sizing
  // ----------------------------------------------------------------
  localparam logic [1:0]  MODE_OFF        = 2'h0;
  localparam logic [1:0]  MODE_SOFTWARE   = 2'h1;
  localparam logic [1:0]  MODE_AWAKE_ONLY = 2'h2;
  localparam logic [1:0]  MODE_ALWAYS     = 2'h3;
  localparam int          CNT_W           = 24;
  localparam int          RATIO_BASE_LOG2 = 5;
  localparam logic [23:0] CNT_ZERO        = 24'h000000;
  localparam logic [23:0] CNT_ONE         = 24'h000001;

  typedef enum logic [0:0] {
    PWR_AWAKE,
    PWR_ASLEEP
  } power_state_t;

  // Divide ratio for a prescale code; reserved codes fall back to the minimum
  function automatic logic [23:0] ratio_of(input logic [4:0] ps);
    logic [23:0] r;
    r = CNT_ONE << RATIO_BASE_LOG2;
    if (ps <= PS_MAX)
    begin
      r = CNT_ONE << (ps + 5'(RATIO_BASE_LOG2));
    end
    return r;
  endfunction

endpackage

// ### wdt_tick_if.sv
`timescale 1ns/100ps
`default_nettype none
interface wdt_tick_if;
  logic clk_sel;
  logic tick;
  modport src
  (
    input  clk_sel,
    output tick
  );
  modport sink
  (
    output clk_sel,
    input  tick
  );
endinterface
`default_nettype wire

// ### wdt_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none
module wdt_tick_gen
  import wdt_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic lf_osc_pin,
  input  wire logic mf_osc_pin,
  wdt_tick_if.src   tick_bus
);

  // ----------------------------------------------------------------
  // Oscillator synchronisers and edge detect
  // ----------------------------------------------------------------
  // Index 0 low-frequency source, index 1 medium-frequency source
  logic [1:0] meta_reg;
  logic [1:0] meta_next;
  logic [1:0] sync_reg;
  logic [1:0] sync_next;
  logic [1:0] last_reg;
  logic [1:0] last_next;
  logic       tick_reg;
  logic       tick_next;
  logic [1:0] rise;

  // Rising edges seen only after the second stage, never on the first
  always_comb
  begin
    meta_next = {mf_osc_pin, lf_osc_pin};
    sync_next = meta_reg;
    last_next = sync_reg;
    rise      = sync_reg & ~last_reg;
    tick_next = tick_bus.clk_sel ? rise[1] : rise[0];
  end

  // Oscillators must run well below sys_clk for edges to be caught
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      meta_reg <= 2'h0;
      sync_reg <= 2'h0;
      last_reg <= 2'h0;
      tick_reg <= 1'h0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_bus.tick = tick_reg;

  tick_sel_a: assert property (@(posedge sys_clk) disable iff (reset)
    (tick_bus.clk_sel && sync_reg[1] && !last_reg[1]) |=> tick_reg)
    else $error("selected medium clock edge gave no tick");

endmodule
`default_nettype wire

// ### cpu_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Firmware core model: issues clear and sleep instructions
// ----------------------------------------------------------------
module cpu_core_model
(
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic cpu_clock_enable,
  input  wire logic wake_resume,
  input  wire logic req_clear,
  input  wire logic req_sleep,
  input  wire logic irq_level,
  input  wire logic gie_level,
  output logic      clear_watchdog_instruction,
  output logic      sleep_instruction,
  output logic      enabled_irq_pending,
  output logic      global_interrupt_enable
);
  logic nop_slot_reg;
  logic run;

  // A stopped core fetches nothing; the slot after wake holds a no-op
  assign run = cpu_clock_enable & ~nop_slot_reg;

  // Registered like a pipeline stage, so requests change after an edge
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      nop_slot_reg               <= 1'h0;
      clear_watchdog_instruction <= 1'h0;
      sleep_instruction          <= 1'h0;
      enabled_irq_pending        <= 1'h0;
      global_interrupt_enable    <= 1'h0;
    end
    else
    begin
      nop_slot_reg               <= wake_resume;
      clear_watchdog_instruction <= req_clear & run;
      sleep_instruction          <= req_sleep & run;
      enabled_irq_pending        <= irq_level;
      global_interrupt_enable    <= gie_level;
    end
  end
endmodule
`default_nettype wire

// ### test_wdt_sleep_core.sv
`timescale 1ns/100ps
`default_nettype none
module test_wdt_sleep_core
  import wdt_pkg::*;
;
  logic              sys_clk = 1'h0;
  logic              reset = 1'h1;
  logic [ADDR_W-1:0] reg_addr = 12'h000;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic              reg_write = 1'h0;
  logic              reg_read = 1'h0;
  logic [DATA_W-1:0] reg_rdata;
  logic [1:0]        mode_sel = 2'h3;
  logic              lf_osc = 1'h0;
  logic              mf_osc = 1'h0;
  logic              req_clear = 1'h0;
  logic              req_sleep = 1'h0;
  logic              irq_level = 1'h0;
  logic              gie_level = 1'h0;
  logic              clr_i, slp_i, irq_i, gie_i;
  logic              watchdog_reset_request, cpu_clock_enable, sleeping;
  logic              wake_resume, wake_to_isr;
  int                num_errors = 0;
  int                comparisons = 0;
  int                cycles = 0;
  logic [7:0]        t2_ctrl [5] = '{8'h80, 8'h00, 8'h82, 8'hA6, 8'hBE};
  int                t2_lo [5] = '{244, 368, 500, 244, 244};
  int                t2_hi [5] = '{268, 396, 524, 268, 268};
  logic [1:0]        t4_mode [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
  logic [7:0]        t4_ctrl [5] = '{8'h81, 8'h80, 8'h81, 8'h80, 8'h80};

  // ----------------------------------------------------------------
  // Clocks: system clock and two free-running slow oscillators
  // ----------------------------------------------------------------
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    #3;
    forever #60 lf_osc = ~lf_osc;
  end
  initial
  begin
    #7;
    forever #40 mf_osc = ~mf_osc;
  end

  wdt_sleep_core u_wdt_sleep_core
  (
    .sys_clk                    (sys_clk),
    .reset                      (reset),
    .reg_addr                   (reg_addr),
    .reg_wdata                  (reg_wdata),
    .reg_write                  (reg_write),
    .reg_read                   (reg_read),
    .reg_rdata                  (reg_rdata),
    .watchdog_mode_select       (mode_sel),
    .lf_osc_pin                 (lf_osc),
    .mf_osc_pin                 (mf_osc),
    .clear_watchdog_instruction (clr_i),
    .sleep_instruction          (slp_i),
    .enabled_irq_pending        (irq_i),
    .global_interrupt_enable    (gie_i),
    .watchdog_reset_request     (watchdog_reset_request),
    .cpu_clock_enable           (cpu_clock_enable),
    .sleeping                   (sleeping),
    .wake_resume                (wake_resume),
    .wake_to_isr                (wake_to_isr)
  );

  cpu_core_model u_cpu_core_model
  (
    .sys_clk                    (sys_clk),
    .reset                      (reset),
    .cpu_clock_enable           (cpu_clock_enable),
    .wake_resume                (wake_resume),
    .req_clear                  (req_clear),
    .req_sleep                  (req_sleep),
    .irq_level                  (irq_level),
    .gie_level                  (gie_level),
    .clear_watchdog_instruction (clr_i),
    .sleep_instruction          (slp_i),
    .enabled_irq_pending        (irq_i),
    .global_interrupt_enable    (gie_i)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge sys_clk);
    reg_write <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge sys_clk);
    reg_read <= 1'h0;
    #1;
    check(reg_rdata, exp);
  endtask

  task automatic pulse_sleep();
    @(posedge sys_clk);
    req_sleep <= 1'h1;
    @(posedge sys_clk);
    req_sleep <= 1'h0;
  endtask

  // Waits for a reset request (sel 0) or a wake (sel 1) inside a window
  task automatic wait_pulse(input logic sel, input int lo, input int hi);
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    while (!watchdog_reset_request && !wake_resume && n <= hi);
    check({6'h00, watchdog_reset_request, wake_resume}, sel ? 8'h01 : 8'h02);
    check({7'h00, 1'(n >= lo && n <= hi)}, 8'h01);
  endtask

  task automatic idle_check(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      #1;
      check({6'h00, watchdog_reset_request, wake_resume}, 8'h00);
    end
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    reset <= 1'h1;
    repeat (4) @(posedge sys_clk);
    reset <= 1'h0;
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard: the whole sequence needs about 6400 cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      num_errors++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'h0;
    reg_rd(CTRL_ADDR, 8'h16);
    reg_rd(STATUS_ADDR, 8'h07);
    reg_rd(12'h800, 8'h00);
    $display("test 1 done");
    // Clock source, prescale codes and reserved codes, mode always on
    for (int i = 0; i < 5; i++)
    begin
      reg_wr(CTRL_ADDR, t2_ctrl[i]);
      wait_pulse(1'h0, t2_lo[i], t2_hi[i]);
      if (i == 0)
        reg_rd(STATUS_ADDR, 8'h03);
    end
    $display("test 2 done");
    // Clear instruction and control writes hold off the timeout
    reg_wr(CTRL_ADDR, 8'h80);
    repeat (6)
    begin
      idle_check(150);
      @(posedge sys_clk);
      req_clear <= 1'h1;
      @(posedge sys_clk);
      req_clear <= 1'h0;
    end
    repeat (3)
    begin
      idle_check(150);
      reg_wr(CTRL_ADDR, 8'h80);
    end
    wait_pulse(1'h0, 244, 268);
    $display("test 3 done");
    // Operating modes while awake
    for (int i = 0; i < 5; i++)
    begin
      @(posedge sys_clk);
      mode_sel <= t4_mode[i];
      reg_wr(CTRL_ADDR, t4_ctrl[i]);
      if (i < 2)
        idle_check(400);
      else
        wait_pulse(1'h0, 244, 268);
    end
    $display("test 4 done");
    // Awake-only mode: sleep holds still, interrupt wakes with both GLOBAL_INTERRUPT_ENABLE values
    do_reset();
    mode_sel <= 2'h2;
    reg_wr(CTRL_ADDR, 8'h80);
    for (int g = 0; g < 2; g++)
    begin
      @(posedge sys_clk);
      gie_level <= 1'(g);
      pulse_sleep();
      @(posedge sys_clk);
      #1;
      check({6'h00, sleeping, cpu_clock_enable}, 8'h02);
      reg_rd(STATUS_ADDR, 8'h06);
      idle_check(400);
      @(posedge sys_clk);
      irq_level <= 1'h1;
      wait_pulse(1'h1, 1, 5);
      check({7'h00, wake_to_isr}, 8'(g));
      check({6'h00, sleeping, cpu_clock_enable}, 8'h01);
      // Interrupt request dropped on an edge, after the wake is seen
      @(posedge sys_clk);
      irq_level <= 1'h0;
      reg_rd(STATUS_ADDR, 8'h06);
    end
    $display("test 5 done");
    // Always-on mode: timeout in sleep wakes without a reset request
    do_reset();
    mode_sel <= 2'h3;
    reg_wr(CTRL_ADDR, 8'h80);
    idle_check(100);
    pulse_sleep();
    wait_pulse(1'h1, 244, 270);
    check({7'h00, sleeping}, 8'h00);
    reg_rd(STATUS_ADDR, 8'h00);
    $display("test 6 done");
    // Pending interrupt turns sleep into a no-op and keeps the count
    do_reset();
    reg_wr(CTRL_ADDR, 8'h80);
    idle_check(100);
    @(posedge sys_clk);
    irq_level <= 1'h1;
    pulse_sleep();
    @(posedge sys_clk);
    #1;
    check({6'h00, sleeping, cpu_clock_enable}, 8'h01);
    reg_rd(STATUS_ADDR, 8'h07);
    @(posedge sys_clk);
    irq_level <= 1'h0;
    wait_pulse(1'h0, 120, 165);
    $display("test 7 done");
    final_report();
  end
endmodule
`default_nettype wire
